/* File: core/asp_tdm.sv */
// Serial audio port with master/slave clocking, four framings and two-slot multiplexing
`timescale 1ns/1ps
`include "asp_map.svh"

module asp_tdm #(
   parameter int BCLK_HALF   = `ASP_BCLK_HALF,
   parameter int FRAME_BCLKS = `ASP_FRAME_BCLKS,
   parameter int POS_W       = 10
) (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [15:0]            reg_rdata,
   input  wire logic              bclk_in,
   output logic                   bclk_out,
   output logic                   bclk_oe,
   input  wire logic              frame_clk_in,
   output logic                   frame_clk_out,
   output logic                   frame_clk_oe,
   output logic                   rec_sample_out,
   output logic                   rec_sample_oe,
   input  wire logic              play_sample_in,
   input  wire asp_pkg::asp_pair_t rec_data,
   output logic                   rec_taken,
   output asp_pkg::asp_pair_t     play_data,
   output logic                   play_valid
);
   import asp_pkg::*;

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   // Slot mode with 32-bit words needs 128 bit clocks a frame; the
   // frame length is left to the integrator rather than refused here
   initial begin
      if (BCLK_HALF < 2) begin
         $error("asp_tdm: bit clock half period below two system clocks");
      end
      if (FRAME_BCLKS < 4 || FRAME_BCLKS % 2 != 0) begin
         $error("asp_tdm: frame length must be even and at least four");
      end
      if (FRAME_BCLKS >= 2 ** POS_W || POS_W > 16) begin
         $error("asp_tdm: position counter too narrow for the frame");
      end
   end

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic int wl_bits(input asp_wl_t code);
      unique case (code)
         WL_16: wl_bits = 16;
         WL_20: wl_bits = 20;
         WL_24: wl_bits = 24;
         WL_32: wl_bits = 32;
      endcase
   endfunction

   // Frame start: DSP on the pulse's rising edge, other framings on any edge
   function automatic logic frame_edge(input asp_fmt_t fmt,
                                       input logic     now,
                                       input logic     was);
      frame_edge = (fmt == FMT_DSP) ? (now & ~was) : (now ^ was);
   endfunction

   // Bit position at the coming rise; saturates so an unframed line stays put
   function automatic logic [POS_W-1:0] pos_step(input logic             tick,
                                                 input logic [POS_W-1:0] cur);
      pos_step = tick ? '0 : ((&cur) ? cur : cur + 1'b1);
   endfunction

   // Locates bit position pos within a slot word; ch is the phase for non-DSP
   function automatic asp_slot_t slot_locate(input logic [POS_W-1:0] pos,
                                             input logic             ch,
                                             input asp_ctrl_t        c,
                                             input logic             slot_en,
                                             input logic             slot_sel,
                                             input logic [POS_W-1:0] plen);
      int        p;
      int        wl;
      int        start;
      logic      sel;
      asp_slot_t r;
      p     = int'(pos);
      wl    = wl_bits(c.sample_word_length);
      sel   = slot_en & slot_sel;
      start = 0;
      r     = '0;
      r.ch  = ch;
      unique case (c.framing_format)
         FMT_RJ: begin
            // Slot 1 is the last word so that its LSB meets the transition
            start = int'(plen) - (slot_en ? 2 * wl : wl) + (sel ? wl : 0);
         end
         FMT_LJ: begin
            start = sel ? wl : 0;
         end
         FMT_I2S: begin
            start = 1 + (sel ? wl : 0);
         end
         FMT_DSP: begin
            start = (c.frame_polarity_select ? 0 : 1) + (sel ? 2 * wl : 0);
            r.ch  = 1'b0;
            if (p >= start + wl) begin
               start = start + wl;
               r.ch  = 1'b1;
            end
         end
      endcase
      r.hit = (p >= start) && (p < start + wl) && (int'(plen) > 0 ||
              c.framing_format != FMT_RJ);
      r.k   = 6'(p - start);
      slot_locate = r;
   endfunction

   // ------------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------------
   asp_ctrl_t        ctrl;
   logic [15:0]      port_enable;
   logic [7:0]       frame_count;
   logic             frame_seen;
   logic             rec_en;
   logic             play_en;
   logic             master;
   logic [15:0]      status_word;

   assign rec_en  = port_enable[`ASP_ENA_REC_BIT];
   assign play_en = port_enable[`ASP_ENA_PLAY_BIT];
   assign master  = ctrl.port_master_select;
   // Status is packed apart so the read select stays one plain word
   assign status_word = {frame_count, 5'h00, bclk_oe, play_en & frame_seen, frame_seen};

   // Reserved control bits are masked off so they always read zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl        <= asp_ctrl_t'(`ASP_CTRL_RST);
         port_enable <= `ASP_ENA_RST;
      end else if (reg_wr) begin
         if (reg_addr == `ASP_CTRL_OFS) begin
            ctrl <= asp_ctrl_t'(reg_wdata & `ASP_CTRL_MASK);
         end
         if (reg_addr == `ASP_ENA_OFS) begin
            port_enable <= reg_wdata & `ASP_ENA_MASK;
         end
      end
   end

   // Read data stands one cycle, then returns to zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `ASP_CTRL_OFS: reg_rdata <= 16'(ctrl);
            `ASP_ENA_OFS:  reg_rdata <= port_enable;
            `ASP_STAT_OFS: reg_rdata <= status_word;
            default:       reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // ------------------------------------------------------------------
   // Master clock generation
   // ------------------------------------------------------------------
   logic [15:0]      div_cnt;
   logic [POS_W-1:0] mcnt;
   logic [POS_W-1:0] next_mcnt;
   logic             gen_run;
   logic             left_level;

   // Left phase level: high for justified framings, low for I2S, inverted when frame_polarity_select is set
   assign left_level = (ctrl.framing_format != FMT_I2S) ^ ctrl.frame_polarity_select;
   assign gen_run    = master & (rec_en | play_en);
   assign next_mcnt  = (int'(mcnt) == FRAME_BCLKS - 1) ? '0 : mcnt + 1'b1;

   // Divider restarts whenever the port stops, so every run starts alike
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_cnt       <= 16'h0000;
         bclk_out      <= 1'b0;
         mcnt          <= '0;
         frame_clk_out <= 1'b0;
      end else if (!gen_run) begin
         div_cnt       <= 16'h0000;
         bclk_out      <= 1'b0;
         mcnt          <= POS_W'(FRAME_BCLKS - 1);
         frame_clk_out <= ~left_level & (ctrl.framing_format != FMT_DSP);
      end else if (int'(div_cnt) == BCLK_HALF - 1) begin
         div_cnt  <= 16'h0000;
         bclk_out <= ~bclk_out;
         // Frame clock moves only with a falling bit clock edge
         if (bclk_out) begin
            mcnt <= next_mcnt;
            if (ctrl.framing_format == FMT_DSP) begin
               frame_clk_out <= (next_mcnt == '0);
            end else begin
               frame_clk_out <= (int'(next_mcnt) < FRAME_BCLKS / 2) ? left_level : ~left_level;
            end
         end
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   // Clock pins are driven only while master and a direction is active
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bclk_oe      <= 1'b0;
         frame_clk_oe <= 1'b0;
      end else begin
         bclk_oe      <= gen_run;
         frame_clk_oe <= gen_run;
      end
   end

   // ------------------------------------------------------------------
   // Edge tracking, common to master and slave
   // ------------------------------------------------------------------
   logic             bclk_s;
   logic             fc_s;
   logic             bclk_d;
   logic             fc_rise;
   logic             bit_rise;
   logic             bit_fall;
   logic             frame_tick;
   logic [POS_W-1:0] pos;
   logic [POS_W-1:0] plen;
   logic [POS_W-1:0] next_pos;
   logic             rx_ch;

   // One edge detector serves both roles, so timing is the same either way
   assign bclk_s   = master ? bclk_out : bclk_in;
   assign fc_s     = master ? frame_clk_out : frame_clk_in;
   assign bit_rise = bclk_s & ~bclk_d;
   assign bit_fall = ~bclk_s & bclk_d;

   assign frame_tick = frame_edge(ctrl.framing_format, fc_s, fc_rise);
   assign next_pos   = pos_step(frame_tick, pos);
   assign rx_ch      = (fc_s != left_level);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bclk_d      <= 1'b0;
         fc_rise     <= 1'b0;
         pos         <= '1;
         plen        <= '0;
         frame_seen  <= 1'b0;
         frame_count <= 8'h00;
      end else begin
         bclk_d <= bclk_s;
         if (bit_rise) begin
            fc_rise <= fc_s;
            pos     <= next_pos;
            if (frame_tick) begin
               // Phase length feeds right justified placement of the next phase
               plen       <= pos + 1'b1;
               frame_seen <= 1'b1;
               if (ctrl.framing_format == FMT_DSP || !rx_ch) begin
                  frame_count <= frame_count + 8'h01;
               end
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Playback receive
   // ------------------------------------------------------------------
   asp_slot_t        rx_slot;
   logic [23:0]      rx_shift;
   logic [23:0]      rx_word;
   logic [5:0]       rx_last;
   logic [23:0]      play_left;

   // Control changes take effect mid-frame; stop the port before rewriting
   assign rx_slot = slot_locate(next_pos, rx_ch, ctrl, ctrl.play_slot_mode_enable,
                                ctrl.play_slot_select, frame_tick ? pos + 1'b1 : plen);
   // 32-bit words keep only the first 24 bits; the rest is padding
   assign rx_last = (ctrl.sample_word_length == WL_32) ? 6'h17
                                                       : 6'(wl_bits(ctrl.sample_word_length) - 1);
   assign rx_word = {rx_shift[22:0], play_sample_in} << (5'h17 - 5'(rx_last));

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_shift   <= 24'h000000;
         play_left  <= 24'h000000;
         play_data  <= '0;
         play_valid <= 1'b0;
      end else begin
         play_valid <= 1'b0;
         // Bits past the 24th of a 32-bit word are dropped
         if (bit_rise && play_en && rx_slot.hit && rx_slot.k <= rx_last) begin
            rx_shift <= {rx_shift[22:0], play_sample_in};
            if (rx_slot.k == rx_last) begin
               if (!rx_slot.ch) begin
                  play_left <= rx_word;
               end else begin
                  play_data  <= '{left: play_left, right: rx_word};
                  play_valid <= 1'b1;
               end
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Record transmit
   // ------------------------------------------------------------------
   asp_slot_t        tx_slot;
   asp_pair_t        tx_hold;
   logic             tx_tick;
   logic [POS_W-1:0] tx_pos;
   logic             tx_ch;
   logic [4:0]       tx_idx;
   logic [23:0]      tx_word;
   logic             tx_real;

   // Output changes on the falling edge, so predict the coming rising edge
   assign tx_tick = frame_edge(ctrl.framing_format, fc_s, fc_rise);
   assign tx_pos  = pos_step(tx_tick, pos);
   assign tx_ch   = (fc_s != left_level);
   assign tx_slot = slot_locate(tx_pos, tx_ch, ctrl, ctrl.rec_slot_mode_enable,
                                ctrl.rec_slot_select, tx_tick ? pos + 1'b1 : plen);
   assign tx_word = tx_slot.ch ? tx_hold.right : tx_hold.left;
   assign tx_idx  = 5'h17 - 5'(tx_slot.k);
   assign tx_real = tx_slot.k < 6'(wl_bits(ctrl.sample_word_length) < `ASP_REAL_BITS ?
                                   wl_bits(ctrl.sample_word_length) : `ASP_REAL_BITS);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_hold   <= '0;
         rec_taken <= 1'b0;
      end else begin
         rec_taken <= 1'b0;
         // Sample pair is taken once per frame so both channels stay matched
         if (bit_fall && tx_tick && (ctrl.framing_format == FMT_DSP || !tx_ch)) begin
            tx_hold   <= rec_data;
            rec_taken <= rec_en;
         end
      end
   end

   // Record line changes one system clock after a falling bit clock edge
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rec_sample_out <= 1'b0;
         rec_sample_oe  <= 1'b0;
      end else if (!rec_en) begin
         rec_sample_out <= 1'b0;
         rec_sample_oe  <= 1'b0;
      end else if (bit_fall) begin
         if (tx_slot.hit && tx_real) begin
            rec_sample_out <= tx_word[tx_idx];
            rec_sample_oe  <= 1'b1;
         end else if (tx_slot.hit) begin
            // Low 8 bits of a 32-bit word are left to the bus pull
            rec_sample_out <= 1'b0;
            rec_sample_oe  <= 1'b0;
         end else begin
            rec_sample_out <= 1'b0;
            rec_sample_oe  <= ~ctrl.rec_slot_mode_enable;
         end
      end
   end

endmodule

/* File: core/asp_map.svh */
// Register map, field positions, reset values and timing counts of the audio port
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH

`define ASP_CTRL_OFS     8'h07
`define ASP_ENA_OFS      8'h08
`define ASP_STAT_OFS     8'h09

`define ASP_CTRL_RST     16'h000A
`define ASP_CTRL_MASK    16'h1E5F
`define ASP_ENA_MASK     16'h0003
`define ASP_ENA_RST      16'h0000

`define ASP_ENA_REC_BIT  0
`define ASP_ENA_PLAY_BIT 1

`define ASP_MCLK_NS      5
`define ASP_BCLK_NS      80
`define ASP_BCLK_HALF    (`ASP_BCLK_NS / (2 * `ASP_MCLK_NS))
`define ASP_FRAME_BCLKS  64
`define ASP_REAL_BITS    24

`endif

/* File: core/asp_pkg.sv */
// Types shared by the audio serial port
package asp_pkg;

   typedef enum logic [1:0] {FMT_RJ, FMT_LJ, FMT_I2S, FMT_DSP} asp_fmt_t;
   typedef enum logic [1:0] {WL_16, WL_20, WL_24, WL_32} asp_wl_t;

   typedef struct packed {
      logic [2:0] rsv_hi;
      logic       play_slot_mode_enable;
      logic       play_slot_select;
      logic       rec_slot_mode_enable;
      logic       rec_slot_select;
      logic [1:0] rsv_mid;
      logic       port_master_select;
      logic       rsv_lo;
      logic       frame_polarity_select;
      asp_wl_t    sample_word_length;
      asp_fmt_t   framing_format;
   } asp_ctrl_t;

   typedef struct packed {
      logic [23:0] left;
      logic [23:0] right;
   } asp_pair_t;

   typedef struct packed {
      logic       hit;
      logic       ch;
      logic [5:0] k;
   } asp_slot_t;

endpackage

/* File: dv/asp_tdm_monitor.sv */
// Register bus, clock output and pulse assertions for the audio serial port
`timescale 1ns/1ps
`include "asp_map.svh"
module asp_tdm_monitor #(
   parameter int BCLK_HALF = 4
) (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        bclk_out,
   input wire logic        bclk_oe,
   input wire logic        frame_clk_out,
   input wire logic        frame_clk_oe,
   input wire logic        rec_taken,
   input wire logic        play_valid
);
   logic [15:0] ctrl_q;
   logic [1:0]  ena_q;
   logic [7:0]  hi_cnt;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ---------------------------------------------
   // Shadow registers, rebuilt from bus traffic
   // ---------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `ASP_CTRL_RST;
         ena_q  <= 2'h0;
      end else if (reg_wr && reg_addr == `ASP_CTRL_OFS) begin
         ctrl_q <= reg_wdata & `ASP_CTRL_MASK;
      end else if (reg_wr && reg_addr == `ASP_ENA_OFS) begin
         ena_q <= reg_wdata[1:0];
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hi_cnt <= 8'h00;
      end else begin
         hi_cnt <= bclk_out ? hi_cnt + 8'h01 : 8'h00;
      end
   end
   sequence rd_at(logic [7:0] a);
      reg_rd && reg_addr == a;
   endsequence
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   ctrl_read_a: assert property (rd_at(`ASP_CTRL_OFS) |=> reg_rdata == ctrl_q)
      else $error("control register read wrong");
   enable_read_a: assert property (rd_at(`ASP_ENA_OFS) |=> reg_rdata == {14'h0, ena_q})
      else $error("enable register read wrong");
   unmapped_read_a: assert property (reg_rd && !(reg_addr inside {[8'h07:8'h09]})
      |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   clk_pair_a: assert property (bclk_oe == frame_clk_oe)
      else $error("clock enables differ");
   clk_drive_a: assert property (bclk_oe == $past(ctrl_q[6] && ena_q != 2'h0))
      else $error("clock drive does not follow master and enable");
   bclk_high_a: assert property ($fell(bclk_out) && bclk_oe |-> hi_cnt == BCLK_HALF)
      else $error("bit clock high time wrong");
   frame_edge_a: assert property (frame_clk_oe && $past(frame_clk_oe) && $changed(frame_clk_out)
      |-> $fell(bclk_out))
      else $error("frame clock moved off a bit clock fall");
   rec_taken_a: assert property (rec_taken |-> $past(ena_q[0]) ##1 !rec_taken)
      else $error("record take pulse wrong");
   play_valid_a: assert property (play_valid |-> $past(ena_q[1]) ##1 !play_valid)
      else $error("playback valid pulse wrong");
endmodule

/* File: dv/asp_far_codec.sv */
// Far-side codec model: clock source when the port is slave, bit capture and playback source
`timescale 1ns/1ps
module asp_far_codec #(
   parameter int FLEN    = 128,
   parameter int HALF_NS = 25
) (
   input  wire logic            mclk,
   input  wire logic            run,
   input  wire logic            dsp,
   input  wire logic            lead,
   input  wire logic            bclk,
   input  wire logic            fck,
   input  wire logic            rec_line,
   input  wire logic            rec_oe,
   input  wire logic [FLEN-1:0] tx,
   output logic                 gen_bclk,
   output logic                 gen_fck,
   output logic                 play_line
);
   logic cap [FLEN];
   logic coe [FLEN];
   int   pos  = 0;
   logic last = 1'b0;
   initial begin
      gen_bclk  = 1'b0;
      gen_fck   = 1'b0;
      play_line = 1'b0;
   end
   // Whole frames only, so the bit clock stands still between runs
   always begin
      @(posedge mclk);
      // Off the system clock edge so the port never samples a changing pin
      #1;
      while (run) begin
         for (int p = 0; p < FLEN; p++) begin
            gen_fck = dsp ? (p == 0) : ((p < FLEN / 2) ~^ lead);
            #HALF_NS gen_bclk = 1'b1;
            #HALF_NS gen_bclk = 1'b0;
         end
      end
   end
   // Positions count from the first rise after the frame start; the record line is only read
   always @(posedge bclk) begin
      pos      = (fck == lead && last != lead) ? 0 : (pos + 1) % FLEN;
      last     = fck;
      cap[pos] = rec_line;
      coe[pos] = rec_oe;
   end
   always @(negedge bclk) begin
      play_line = tx[(pos + 1) % FLEN];
   end
endmodule

/* File: dv/test_audio_serial_port_tdm.sv */
// Self-checking bench: registers, master framings and slave slot mode of the audio port
`timescale 1ns/1ps
`include "asp_map.svh"
module test_audio_serial_port_tdm;
   import asp_pkg::*;
   localparam int HALF = 4;
   localparam int FLEN = 128;
   localparam int PH   = FLEN / 2;
   logic            mclk = 1'b0;
   logic            rst = 1'b1;
   logic [7:0]      reg_addr = 8'h00;
   logic [15:0]     reg_wdata = 16'h0000;
   logic            reg_wr = 1'b0;
   logic            reg_rd = 1'b0;
   logic [15:0]     reg_rdata;
   logic            bclk_out, bclk_oe, frame_clk_out, frame_clk_oe;
   logic            rec_sample_out, rec_sample_oe, rec_taken, play_valid;
   wire logic       play_sample_in;
   asp_pair_t       rec_data = '0;
   asp_pair_t       play_data;
   logic            run = 1'b0;
   logic            dsp = 1'b0;
   logic            lead = 1'b0;
   logic [FLEN-1:0] tx = '0;
   logic            gen_bclk, gen_fck;
   wire logic       bclk_w = bclk_oe ? bclk_out : gen_bclk;
   wire logic       fck_w = frame_clk_oe ? frame_clk_out : gen_fck;
   // Pull-down on the shared record line
   wire logic       rec_w = rec_sample_oe ? rec_sample_out : 1'b0;
   logic [5:0]      cf [6] = '{6'h00, 6'h15, 6'h0A, 6'h0F, 6'h1B, 6'h29};
   int              err_count = 0;
   int              comparisons = 0;
   always #2.5 mclk = ~mclk;
   asp_tdm #(.BCLK_HALF(HALF), .FRAME_BCLKS(FLEN)) dut_u (
      .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk_in(bclk_w), .bclk_out(bclk_out),
      .bclk_oe(bclk_oe), .frame_clk_in(fck_w), .frame_clk_out(frame_clk_out),
      .frame_clk_oe(frame_clk_oe), .rec_sample_out(rec_sample_out),
      .rec_sample_oe(rec_sample_oe), .play_sample_in(play_sample_in), .rec_data(rec_data),
      .rec_taken(rec_taken), .play_data(play_data), .play_valid(play_valid));
   asp_far_codec #(.FLEN(FLEN), .HALF_NS(25)) pm_u (
      .mclk(mclk), .run(run), .dsp(dsp), .lead(lead), .bclk(bclk_w), .fck(fck_w),
      .rec_line(rec_w), .rec_oe(rec_sample_oe), .tx(tx), .gen_bclk(gen_bclk),
      .gen_fck(gen_fck), .play_line(play_sample_in));
   // ---------------------------------------------
   // Bus tasks and checks
   // ---------------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic bad(input string m);
      err_count++;
      $display("BAD %0t %s", $time, m);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      comparisons++;
      if (reg_rdata !== e) bad("register read");
   endtask
   // Bounded wait on playback words; the third one follows two whole frames
   task automatic frames(input int n);
      int k;
      int kt;
      k  = 0;
      kt = 0;
      for (int t = 0; t < 40000 && k < n; t++) begin
         @(posedge mclk);
         if (play_valid === 1'b1) k++;
         if (rec_taken === 1'b1) kt++;
      end
      if (k < n) begin
         bad("no playback word");
         print_verdict();
      end
      comparisons++;
      if (kt < 2) bad("record pair not taken each frame");
   endtask
   task automatic check(input logic [1:0] fmt, input logic [1:0] wl, input logic pol,
                        input logic sl);
      int          w, r, s, q;
      logic [23:0] el, er;
      w  = (wl == 2'h3) ? 32 : 16 + 4 * wl;
      r  = (w > 24) ? 24 : w;
      s  = (fmt == 2'h0) ? PH - w : ((fmt == 2'h2 || (fmt == 2'h3 && !pol)) ? 1 : 0)
           + (sl ? w * ((fmt == 2'h3) ? 2 : 1) : 0);
      q  = (fmt == 2'h3) ? s + w : s + PH;
      el = '0;
      er = '0;
      for (int b = 0; b < r; b++) begin
         el[23 - b] = tx[s + b];
         er[23 - b] = tx[q + b];
         comparisons++;
         if (pm_u.cap[s + b] !== rec_data.left[23 - b]) bad("record left bit");
         comparisons++;
         if (pm_u.cap[q + b] !== rec_data.right[23 - b]) bad("record right bit");
         comparisons++;
         if (pm_u.coe[s + b] !== 1'b1) bad("record bit not driven");
      end
      comparisons++;
      if (play_data !== {el, er}) bad("playback word");
      comparisons++;
      if (pm_u.coe[s + r] !== !(sl || w == 32)) bad("record release");
      if (sl) begin
         comparisons++;
         if (pm_u.coe[s - 1] !== 1'b0) bad("record before slot");
      end
   endtask
   task automatic run_cfg(input logic m, input logic [1:0] fmt, input logic [1:0] wl,
                          input logic pol, input logic sl);
      logic [63:0] r64;
      r64 = {$urandom(), $urandom()};
      wr(`ASP_ENA_OFS, 16'h0000);
      wr(`ASP_CTRL_OFS, {3'h0, sl, sl, sl, sl, 2'h0, m, 1'b0, pol, wl, fmt});
      rec_data <= r64[47:0];
      tx       <= {r64, $urandom(), $urandom()};
      dsp      <= (fmt == 2'h3);
      lead     <= (fmt == 2'h3) || ((fmt != 2'h2) ^ pol);
      run      <= !m;
      wr(`ASP_ENA_OFS, 16'h0003);
      frames(3);
      check(fmt, wl, pol, sl);
      @(posedge mclk);
      reg_addr <= `ASP_STAT_OFS;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      comparisons++;
      if (reg_rdata[2:0] !== {m, 2'h3}) bad("status bits");
      run <= 1'b0;
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      void'($urandom(32'h3c88));
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rd_chk(`ASP_CTRL_OFS, `ASP_CTRL_RST);
      rd_chk(`ASP_ENA_OFS, `ASP_ENA_RST);
      rd_chk(8'h3F, 16'h0000);
      wr(`ASP_CTRL_OFS, 16'hFFFF);
      rd_chk(`ASP_CTRL_OFS, `ASP_CTRL_MASK);
      for (int i = 0; i < 6; i++) begin
         run_cfg(1'b1, cf[i][1:0], cf[i][3:2], cf[i][4], cf[i][5]);
      end
      run_cfg(1'b0, 2'h2, 2'h3, 1'b0, 1'b1);
      run_cfg(1'b0, 2'h3, 2'h0, 1'b1, 1'b0);
      print_verdict();
   end
endmodule
bind asp_tdm asp_tdm_monitor #(.BCLK_HALF(BCLK_HALF)) mon_u (
   .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
   .frame_clk_out(frame_clk_out), .frame_clk_oe(frame_clk_oe), .rec_taken(rec_taken),
   .play_valid(play_valid));
